/* File: cppwm_top.sv */
// What this block does
// - Writing one to soft reset returns every control field to reset value.
// - Soft reset bit clears itself and always reads back as zero.
// - Shape 00 gives a 16.384 MHz delta-sigma stream of the summed audio.
// - Shape 01 gives balanced pulses centred in each 16 kHz sample period.
// - Shape 10 falls at each 32 kHz boundary, rises at amplitude-proportional point.
// - Enabled with shape 00, 01 or 10, transmit plus receive audio drives the progress output as pulses; shape 11 holds it low.
// - Disabled, the progress output carries no pulse stream.
// - Loopback bit loops data across the barrier through both filters.
// - Shared pin is progress output when select is zero, interrupt when one.
`timescale 1ns/1ps
module cppwm_top
  import cppwm_pkg::*;
#(
  parameter int FIFO_DEPTH = CPPWM_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic           i_core_clk,
  input  wire logic           i_rst_n,
  // Control port.
  input  wire cppwm_reg_req_t i_reg_req,
  output logic          [7:0] o_reg_rdata,
  output logic                o_reg_rvalid,
  // Audio samples.
  input  wire logic           i_audio_valid,
  output logic                o_audio_ready,
  input  wire cppwm_audio_t   i_audio,
  // Shared pin and neighbours.
  input  wire logic           i_interrupt_pin_select,
  input  wire logic           i_interrupt_level,
  output logic                o_shared_progress_interrupt_pin,
  output logic                o_barrier_loopback_enable,
  output logic                o_soft_reset_pulse
);

  logic [7:0]             ctrl;
  logic [7:0]             next_ctrl;
  logic [7:0]             rdata;
  logic [7:0]             next_rdata;
  logic                   rvalid;
  logic                   soft_rst;
  logic                   next_soft_rst;
  logic [31:0]            phase;
  logic [31:0]            next_phase;
  logic                   tick;
  logic                   next_tick;
  logic [9:0]             pos;
  logic [9:0]             next_pos;
  logic [15:0]            level;
  logic [15:0]            next_level;
  logic [16:0]            ds_acc;
  logic [16:0]            next_ds_acc;
  logic                   pin;
  logic                   next_pin;
  logic                   pwm_bit;
  logic                   fifo_valid;
  logic                   fifo_pop;
  cppwm_audio_t           fifo_data;
  logic signed [16:0]     sum;
  logic [15:0]            samp_u;
  logic [10:0]            lo;
  logic                   frame_end;

  function automatic logic ctrl_hit(input cppwm_reg_req_t req);
    ctrl_hit = (req.addr == CPPWM_PRIMARY_CTRL);
  endfunction : ctrl_hit

  always_comb begin
    next_ctrl     = ctrl;
    next_soft_rst = 1'b0;
    next_rdata    = rdata;
    if (i_reg_req.wr && ctrl_hit(i_reg_req)) begin
      if (i_reg_req.wdata[CPPWM_SOFT_RST_BIT]) begin
        next_ctrl     = CPPWM_CTRL_RESET;
        next_soft_rst = 1'b1;
      end else begin
        next_ctrl = i_reg_req.wdata & CPPWM_CTRL_WMASK;
      end
    end
    if (i_reg_req.rd) begin
      next_rdata = ctrl_hit(i_reg_req) ? (ctrl & CPPWM_CTRL_WMASK) : 8'h00;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl     <= CPPWM_CTRL_RESET;
      soft_rst <= 1'b0;
      rdata    <= 8'h00;
      rvalid   <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      soft_rst <= next_soft_rst;
      rdata    <= next_rdata;
      rvalid   <= i_reg_req.rd;
    end
  end

  assign o_reg_rdata        = rdata;
  assign o_reg_rvalid       = rvalid;
  assign o_soft_reset_pulse = soft_rst;
  // loopback level for the barrier path.
  assign o_barrier_loopback_enable = ctrl[CPPWM_LOOP_BIT];

  // The FIFO absorbs bursty sample delivery; it drains one word per sample period.
  cppwm_fifo #(
    .WIDTH ($bits(cppwm_audio_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_clear     (soft_rst),
    .i_in_valid  (i_audio_valid),
    .o_in_ready  (o_audio_ready),
    .i_in_data   (i_audio),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );

  assign frame_end = tick && (pos == 10'(CPPWM_FRAME_TICKS - 1));
  assign fifo_pop  = frame_end;

  // sum both audio paths; loopback returns transmit as receive.
  always_comb begin
    sum = 17'(fifo_data.tx) + (ctrl[CPPWM_LOOP_BIT] ? 17'(fifo_data.tx) : 17'(fifo_data.rx));
    samp_u = {~sum[16], sum[15:1]};
  end

  // bit clock, sample framing and pulse shaping.
  always_comb begin
    next_phase  = phase + CPPWM_TICK_INC;
    next_tick   = (next_phase < phase);
    next_pos    = tick ? pos + 10'h001 : pos;
    next_level  = (frame_end && fifo_valid) ? samp_u : level;
    next_ds_acc = tick ? ({1'b0, ds_acc[15:0]} + {1'b0, level}) : ds_acc;
    lo          = 11'h200 - {2'h0, level[15:7]};
    case (ctrl[CPPWM_SHAPE_LSB +: 2])
      CPPWM_SHAPE_DS:     pwm_bit = ds_acc[16];
      CPPWM_SHAPE_CENTER: pwm_bit = ({1'b0, pos} >= lo) && ({1'b0, pos} < lo + 11'(level[15:6]));
      CPPWM_SHAPE_TRAIL:  pwm_bit = pos[8:0] > level[15:7];
      default:            pwm_bit = 1'b0;
    endcase
    // interrupt mode takes the pin over.
    if (i_interrupt_pin_select) begin
      next_pin = i_interrupt_level;
    end else if (ctrl[CPPWM_EN_BIT]) begin
      next_pin = pwm_bit;
    end else begin
      next_pin = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || soft_rst) begin
      phase  <= 32'h0000_0000;
      tick   <= 1'b0;
      pos    <= 10'h000;
      level  <= 16'h8000;
      ds_acc <= 17'h0_0000;
    end else begin
      phase  <= next_phase;
      tick   <= next_tick;
      pos    <= next_pos;
      level  <= next_level;
      ds_acc <= next_ds_acc;
    end
  end

  // Soft reset leaves the pin register alone, so an interrupt level is never cut short.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pin <= 1'b0;
    end else begin
      pin <= next_pin;
    end
  end

  assign o_shared_progress_interrupt_pin = pin;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_soft_reset_ctrl : assert property (
    i_reg_req.wr && ctrl_hit(i_reg_req) && i_reg_req.wdata[7] |=> ctrl == CPPWM_CTRL_RESET && soft_rst)
    else $error("Soft reset did not restore control.");
  a_soft_rst_selfclear : assert property (
    soft_rst |=> !soft_rst) else $error("Soft reset pulse stuck.");
  a_rsvd_read_zero : assert property (
    rvalid |-> (rdata & 8'hC5) == 8'h00) else $error("Reserved or reset bit read nonzero.");
  a_tick_spacing : assert property (
    tick |=> !tick [*6]) else $error("Bit clock enable faster than 16.384 MHz.");
  a_trail_fall : assert property (
    !i_interrupt_pin_select && ctrl[5:3] == 3'b101 && pos[8:0] == 9'h000 |=> !pin)
    else $error("Trailing mode not low at period start.");
  a_center_mid : assert property (
    !i_interrupt_pin_select && ctrl[5:3] == 3'b011 && pos == 10'h1FF && level[15:7] > 9'h002
    |=> pin) else $error("Centred pulse not high at period middle.");
  a_disabled_quiet : assert property (
    !i_interrupt_pin_select && !ctrl[CPPWM_EN_BIT] |=> !pin) else $error("Pulses while disabled.");
  a_int_route : assert property (
    i_interrupt_pin_select |=> pin == $past(i_interrupt_level)) else $error("Interrupt not on pin.");
  a_loop_follow : assert property (
    i_reg_req.wr && ctrl_hit(i_reg_req) && !i_reg_req.wdata[CPPWM_SOFT_RST_BIT]
    |=> o_barrier_loopback_enable == $past(i_reg_req.wdata[CPPWM_LOOP_BIT]))
    else $error("Loopback level does not follow the written bit.");
  a_rvalid_pulse : assert property (
    i_reg_req.rd |=> rvalid) else $error("Read not answered next cycle.");
  a_level_update : assert property (
    frame_end && fifo_valid && !soft_rst |=> level == $past(samp_u))
    else $error("Sample not taken at frame end.");

  c_mode_ds : cover property (ctrl[5:3] == 3'b001 && pin);
  c_mode_center : cover property (ctrl[5:3] == 3'b011 && frame_end);
  c_mode_trail : cover property (ctrl[5:3] == 3'b101 && $rose(pin));
  c_soft_reset : cover property (soft_rst);

endmodule : cppwm_top

/* File: cppwm_pkg.sv */
package cppwm_pkg;

  localparam int          CPPWM_REG_W          = 8;
  localparam int          CPPWM_SMP_W          = 16;
  localparam logic [7:0]  CPPWM_PRIMARY_CTRL   = 8'h01;
  localparam logic [7:0]  CPPWM_CTRL_RESET     = 8'h00;
  localparam logic [7:0]  CPPWM_CTRL_WMASK     = 8'h3A;
  localparam int          CPPWM_SOFT_RST_BIT   = 7;
  localparam int          CPPWM_SHAPE_LSB      = 4;
  localparam int          CPPWM_EN_BIT         = 3;
  localparam int          CPPWM_LOOP_BIT       = 1;
  localparam logic [1:0]  CPPWM_SHAPE_DS       = 2'h0;
  localparam logic [1:0]  CPPWM_SHAPE_CENTER   = 2'h1;
  localparam logic [1:0]  CPPWM_SHAPE_TRAIL    = 2'h2;

  localparam longint      CPPWM_CORE_HZ        = 125000000;
  localparam longint      CPPWM_BIT_HZ         = 16384000;
  localparam longint      CPPWM_SAMPLE_HZ      = 16000;
  localparam longint      CPPWM_HALF_HZ        = 32000;
  localparam logic [31:0] CPPWM_TICK_INC       =
    32'((CPPWM_BIT_HZ * 64'h1_0000_0000) / CPPWM_CORE_HZ);
  localparam int          CPPWM_FRAME_TICKS    = int'(CPPWM_BIT_HZ / CPPWM_SAMPLE_HZ);
  localparam int          CPPWM_HALF_TICKS     = int'(CPPWM_BIT_HZ / CPPWM_HALF_HZ);
  localparam int          CPPWM_FIFO_DEPTH     = 16;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cppwm_reg_req_t;

  typedef struct packed {
    logic signed [CPPWM_SMP_W-1:0] tx;
    logic signed [CPPWM_SMP_W-1:0] rx;
  } cppwm_audio_t;

endpackage : cppwm_pkg

/* File: cppwm_fifo.sv */
`timescale 1ns/1ps
module cppwm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  // Fill side.
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side.
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    if (i_clear) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  a_fifo_no_overrun : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    count == (AW+1)'(DEPTH) |-> !o_in_ready) else $error("FIFO accepts while full.");
  a_fifo_count_step : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clear && push && !pop |=> count == $past(count) + (AW+1)'(1))
    else $error("FIFO count did not rise on a push.");

endmodule : cppwm_fifo

/* File: cppwm_filter_model.sv */
`timescale 1ns/1ps
// A low-pass filter keeps only the average of the stream, so counting high
// cycles over a window is all this stand-in needs; it never loads the pin.
module cppwm_filter_model (
  // Clock and pin.
  input  wire logic i_core_clk,
  input  wire logic i_pin,
  // Window control and result.
  input  wire logic i_measure,
  output int        o_high,
  output int        o_total
);
  always_ff @(posedge i_core_clk) begin
    if (!i_measure) begin
      o_high  <= 0;
      o_total <= 0;
    end else begin
      o_high  <= o_high + int'(i_pin);
      o_total <= o_total + 1;
    end
  end
endmodule : cppwm_filter_model

/* File: cppwm_top_tb.sv */
`timescale 1ns/1ps
module cppwm_top_tb;
  import cppwm_pkg::*;
  logic           clk      = 1'b0;
  logic           rst_n    = 1'b0;
  cppwm_reg_req_t req      = '0;
  cppwm_audio_t   aud      = '0;
  logic           a_valid  = 1'b0;
  logic           int_sel  = 1'b0;
  logic           int_lvl  = 1'b0;
  logic           meas     = 1'b0;
  logic [7:0]     rdata;
  logic           rvalid, a_ready, pin, loop_en, soft_pulse;
  int             n_fail   = 0;
  int             tests_run = 0;
  int             hi, tot;

  always #4 clk = ~clk;

  cppwm_top cppwm_top_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_audio_valid(a_valid), .o_audio_ready(a_ready),
    .i_audio(aud), .i_interrupt_pin_select(int_sel), .i_interrupt_level(int_lvl),
    .o_shared_progress_interrupt_pin(pin), .o_barrier_loopback_enable(loop_en),
    .o_soft_reset_pulse(soft_pulse));

  cppwm_filter_model cppwm_filter_model_i (
    .i_core_clk(clk), .i_pin(pin), .i_measure(meas), .o_high(hi), .o_total(tot));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) req <= '0;
    #1;
  endtask : wr

  // A missing rvalid turns the data unknown, so the caller's compare fails.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) req <= '0;
    #1 d = rvalid ? rdata : 8'hXX;
  endtask : rd

  task automatic push(input int n);
    @(posedge clk) a_valid <= 1'b1;
    repeat (n) @(posedge clk);
    a_valid <= 1'b0;
    #1;
  endtask : push

  task automatic measure(input int n);
    @(posedge clk) meas <= 1'b1;
    repeat (n) @(posedge clk);
    meas <= 1'b0;
    #1;
  endtask : measure

  function automatic real dens(input logic [1:0] s, input int tx, input int rx);
    int l;
    l = (tx + rx) / 2 + 32768;
    case (s)
      2'h0: return l / 65536.0;
      2'h1: return (l >> 6) / 1024.0;
      default: return (511 - (l >> 7)) / 512.0;
    endcase
  endfunction : dens

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial begin : watchdog
    #(8 * 90000);
    n_fail++;
    give_verdict();
  end

  initial begin : main
    logic [7:0] d, w;
    int         tx, rx;
    real        m;
    void'($urandom(32'h31f1));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(CPPWM_PRIMARY_CTRL, d);
    chk(d, 8'h00);
    repeat (6) begin
      w = 8'($urandom) & 8'h7F;
      wr(CPPWM_PRIMARY_CTRL, w);
      rd(CPPWM_PRIMARY_CTRL, d);
      chk(d, w & 8'h3A);
    end
    wr(8'h02, 8'hFF);
    rd(8'h02, d);
    chk(d, 8'h00);
    rd(CPPWM_PRIMARY_CTRL, d);
    chk(d, w & 8'h3A);
    $display("test registers done");
    wr(CPPWM_PRIMARY_CTRL, 8'h1A);
    chk({7'h0, loop_en}, 8'h01);
    wr(CPPWM_PRIMARY_CTRL, 8'hBA);
    chk({7'h0, soft_pulse}, 8'h01);
    rd(CPPWM_PRIMARY_CTRL, d);
    chk(d, 8'h00);
    chk({7'h0, loop_en}, 8'h00);
    aud <= '{tx: 16'sh0100, rx: 16'sh0100};
    push(16);
    chk({7'h0, a_ready}, 8'h00);
    wr(CPPWM_PRIMARY_CTRL, 8'h80);
    @(posedge clk);
    #1 chk({7'h0, a_ready}, 8'h01);
    $display("test soft reset done");
    wr(CPPWM_PRIMARY_CTRL, 8'h10);
    push(4);
    measure(4000);
    chk({7'h0, hi == 0}, 8'h01);
    $display("test disabled done");
    for (int k = 0; k < 4; k++) begin
      wr(CPPWM_PRIMARY_CTRL, 8'h80);
      tx = int'($urandom_range(16000)) - 8000;
      rx = int'($urandom_range(16000)) - 8000;
      aud <= '{tx: 16'(tx), rx: 16'(rx)};
      // line side assumed enabled and off-hook before loopback.
      wr(CPPWM_PRIMARY_CTRL, {2'b00, 2'(k % 3), 1'b1, 1'b0, k == 3, 1'b0});
      chk({7'h0, loop_en}, {7'h0, k == 3});
      push(4);
      repeat (8000) @(posedge clk);
      measure(7813);
      m = real'(hi) / real'(tot) - dens(2'(k % 3), tx, (k == 3) ? tx : rx);
      chk({7'h0, m < 0.05 && m > -0.05}, 8'h01);
      $display("test shape %0d done", k);
    end
    d[0] = 1'b0;
    @(posedge clk) int_sel <= 1'b1;
    @(posedge clk);
    repeat (20) begin
      w[0] = 1'($urandom);
      @(posedge clk) int_lvl <= w[0];
      #1 chk({7'h0, pin}, {7'h0, d[0]});
      d[0] = w[0];
    end
    $display("test interrupt select done");
    give_verdict();
  end
endmodule : cppwm_top_tb
